//--- dv/dpl_phase_loop_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpl_regs.svh"

module dpl_phase_loop_checker
    import dpl_pkg::*;
#(
    parameter int CNT_W = 18,
    parameter int FINE_W = 16,
    parameter int PE_W = 40,
    parameter int ACC_W = 64
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic refEdge,
    input wire logic fbEdge,
    input wire logic signed [FINE_W-1:0] fineRaw,
    input wire logic [`DPL_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic signed [PE_W-1:0] phaseErr,
    input wire logic errValid,
    input wire logic [47:0] ftw,
    input wire logic [47:0] ddsPhase
);
    logic fineWrReg;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Remembers a fine word write since reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            fineWrReg <= 1'b0;
        else if (regWr && regAddr == `DPL_OFS_FINE)
            fineWrReg <= 1'b1;
    end

    a_dds_accum: assert property (!$past(rst) |->
        ddsPhase == 48'($past(ddsPhase) + $past(ftw))) else $error("accumulator step wrong");
    a_err_pulse: assert property (errValid |=> !errValid)
        else $error("valid strobe too long");
    a_err_hold: assert property (!$past(rst) && !errValid |-> $stable(phaseErr))
        else $error("phase error moved without strobe");
    a_ftw_cause: assert property ($changed(ftw) |-> $past(errValid) ||
        $past(errValid, 2) || $past(errValid, 3) || $past(regWr) || $past(regWr, 2) ||
        $past(regWr, 3)) else $error("tuning word changed without cause");
    a_fine_reset: assert property (regRd && regAddr == `DPL_OFS_FINE && !fineWrReg
        |=> regRdata == 32'h0000C805) else $error("fine word reset value wrong");
    a_alpha_clamp: assert property (regRd && regAddr == `DPL_OFS_ALPHA
        |=> regRdata[20:16] <= 5'h16) else $error("alpha up-shift above limit");
    a_beta_mant: assert property (regRd && regAddr == `DPL_OFS_BETA
        |=> regRdata[15:12] == 4'h0) else $error("beta mantissa too wide");
    a_gamma_mant: assert property (regRd && regAddr == `DPL_OFS_GAMMA
        |=> regRdata[15:12] == 4'h0) else $error("gamma mantissa too wide");
endmodule // dpl_phase_loop_checker

bind dpl_phase_loop dpl_phase_loop_checker #(.CNT_W(CNT_W), .FINE_W(FINE_W), .PE_W(PE_W),
    .ACC_W(ACC_W)) u_dpl_phase_loop_checker (.clk(clk), .rst(rst), .refEdge(refEdge),
    .fbEdge(fbEdge), .fineRaw(fineRaw), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .phaseErr(phaseErr),
    .errValid(errValid), .ftw(ftw), .ddsPhase(ddsPhase));

`default_nettype wire

//--- dv/dpl_phase_loop_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpl_regs.svh"

module dpl_phase_loop_test;
    logic clk, rst, regWr, regRd, errValid, refEdge, fbEdge;
    logic signed [15:0] fineRaw;
    logic [3:0] regAddr;
    logic [31:0] regWdata, regRdata;
    logic signed [39:0] phaseErr;
    logic [47:0] ftw, ddsPhase, lastFtw;
    int numErrors, nCompared, cycles;
    int ce[4] = '{0, 0, 2, 7};
    int cm[4] = '{1, 1, 5, 63};
    int cd[4] = '{3, -3, 7, 2};

    dpl_phase_loop u_dpl_phase_loop (.clk(clk), .rst(rst), .refEdge(refEdge),
        .fbEdge(fbEdge), .fineRaw(fineRaw), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .phaseErr(phaseErr),
        .errValid(errValid), .ftw(ftw), .ddsPhase(ddsPhase));
    dpl_ref_source u_dpl_ref_source (.clk(clk), .refEdge(refEdge), .fbEdge(fbEdge),
        .fineRaw(fineRaw));

    // Compare and count
    task automatic chk(input string nm, input logic [47:0] got, input logic [47:0] exp);
        nCompared++;
        if (got !== exp) begin
            numErrors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // One-cycle read, data checked in the following cycle
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk("regRdata", {16'h0, regRdata}, {16'h0, exp});
    endtask

    // Waits for n loop ticks
    task automatic waitv(input int n);
        repeat (n) @(posedge clk iff errValid);
        #1;
    endtask

    task automatic finishTest();
        $display("compared %0d, errors %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            numErrors++;
            finishTest();
        end
    end

    // Test sequence
    initial begin
        {rst, regWr, regRd, regAddr, regWdata} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(`DPL_OFS_FINE, 32'h0000C805);
        rd(`DPL_OFS_CTRL, 32'h00000400);
        wr(4'hC, 32'h12345678);
        rd(4'hC, 32'h0);
        wr(`DPL_OFS_ALPHA, 32'h011F0FFF);
        rd(`DPL_OFS_ALPHA, 32'h01160FFF);
        wr(`DPL_OFS_BETA, 32'h00070D41);
        rd(`DPL_OFS_BETA, 32'h00070D41);
        wr(`DPL_OFS_GAMMA, 32'h00070FFF);
        rd(`DPL_OFS_GAMMA, 32'h00070FFF);
        $display("registers done");
        wr(`DPL_OFS_CTRL, 32'h00000200);
        wr(`DPL_OFS_FINE, 32'h00000001);
        for (int i = 0; i < 4; i++) begin
            wr(`DPL_OFS_COARSE, 32'(cm[i] << 8 | ce[i]));
            u_dpl_ref_source.pair(cd[i]);
            waitv(2);
            chk("coarse phaseErr", 48'(phaseErr), 48'((cd[i] * cm[i]) <<< (ce[i] + 6)));
        end
        $display("coarse done");
        wr(`DPL_OFS_COARSE, 32'h0);
        wr(`DPL_OFS_FINE, 32'h00000302);
        u_dpl_ref_source.setFine(16'sd10);
        waitv(4);
        chk("fine phaseErr", 48'(phaseErr), 48'd30);
        $display("fine done");
        wr(`DPL_OFS_OPEN_LO, 32'h89ABCDEF);
        wr(`DPL_OFS_OPEN_HI, 32'h0000FFFF);
        repeat (3) @(posedge clk);
        #1 chk("open ftw", ftw, 48'hFFFF89ABCDEF);
        rd(`DPL_OFS_FTW_HI, 32'h0000FFFF);
        wr(`DPL_OFS_ALPHA, 32'h00000800);
        wr(`DPL_OFS_BETA, 32'h0);
        wr(`DPL_OFS_GAMMA, 32'h0);
        wr(`DPL_OFS_CTRL, 32'h00000201);
        u_dpl_ref_source.setFine(16'sd20);
        waitv(6);
        lastFtw = ftw;
        waitv(2);
        repeat (3) @(posedge clk);
        #1 chk("closed ftw varies", 48'(ftw !== lastFtw), 48'h1);
        $display("closed loop done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`DPL_OFS_FINE, 32'h0000C805);
        $display("second reset done");
        finishTest();
    end
endmodule // dpl_phase_loop_test

`default_nettype wire

//--- dv/dpl_ref_source.sv
`timescale 1ns/1ps
`default_nettype none

module dpl_ref_source #(
    parameter int FINE_W = 16
) (
    input wire logic clk,
    output var logic refEdge,
    output var logic fbEdge,
    output var logic signed [FINE_W-1:0] fineRaw
);
    // Edge lines idle low between pairs
    initial begin
        refEdge = 1'b0;
        fbEdge = 1'b0;
        fineRaw = '0;
    end

    // One edge pair, |d| cycles apart; negative d sends feedback first
    task automatic pair(input int d);
        int n;
        n = (d < 0) ? -d : d;
        @(posedge clk);
        refEdge <= (d > 0);
        fbEdge <= (d < 0);
        @(posedge clk);
        refEdge <= 1'b0;
        fbEdge <= 1'b0;
        repeat (n - 1) @(posedge clk);
        refEdge <= (d < 0);
        fbEdge <= (d > 0);
        @(posedge clk);
        refEdge <= 1'b0;
        fbEdge <= 1'b0;
        repeat (16) @(posedge clk);
    endtask

    // New fine measurement level
    task automatic setFine(input logic signed [FINE_W-1:0] v);
        @(posedge clk);
        fineRaw <= v;
    endtask
endmodule // dpl_ref_source

`default_nettype wire

//--- hw/dpl_phase_loop.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpl_regs.svh"

module dpl_phase_loop
    import dpl_pkg::*;
#(
    parameter int CNT_W = 18,
    parameter int FINE_W = 16,
    parameter int PE_W = 40,
    parameter int ACC_W = 64
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic refEdge,
    input wire logic fbEdge,
    input wire logic signed [FINE_W-1:0] fineRaw,
    input wire logic [`DPL_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic signed [PE_W-1:0] phaseErr,
    output logic errValid,
    output logic [47:0] ftw,
    output logic [47:0] ddsPhase
);

    // Software-visible control fields
    logic closeLoop_reg;
    logic [4:0] loopDivExp_reg;
    logic [2:0] coarseExp_reg;
    logic [5:0] coarseMult_reg;
    logic [3:0] fineDiv_reg;
    logic [7:0] fineGain_reg;
    logic [11:0] alphaMant_reg;
    logic [4:0] alphaUp_reg;
    logic [2:0] alphaDown_reg;
    logic [11:0] betaMant_reg;
    logic [2:0] betaShift_reg;
    logic [11:0] gammaMant_reg;
    logic [2:0] gammaShift_reg;
    logic [47:0] openFtw_reg;

    // Detector and filter state
    dpl_coarse_e coarseState_reg, coarseState_next;
    logic [CNT_W-1:0] coarseCnt_reg, coarseCnt_next;
    logic signed [CNT_W:0] coarseMeas_reg, coarseMeas_next;
    logic [5:0] fineCnt_reg;
    logic signed [FINE_W-1:0] fineSample_reg;
    logic [31:0] loopCnt_reg;
    logic signed [ACC_W-1:0] x1_reg, x2_reg, u1_reg, y_reg;

    // Register decode
    wire wrCtrl = regWr && (regAddr == `DPL_OFS_CTRL);
    wire wrCoarse = regWr && (regAddr == `DPL_OFS_COARSE);
    wire wrFine = regWr && (regAddr == `DPL_OFS_FINE);
    wire wrAlpha = regWr && (regAddr == `DPL_OFS_ALPHA);
    wire wrBeta = regWr && (regAddr == `DPL_OFS_BETA);
    wire wrGamma = regWr && (regAddr == `DPL_OFS_GAMMA);
    wire wrOpenLo = regWr && (regAddr == `DPL_OFS_OPEN_LO);
    wire wrOpenHi = regWr && (regAddr == `DPL_OFS_OPEN_HI);

    // Control register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            closeLoop_reg <= 1'b0;
            loopDivExp_reg <= `DPL_RST_LDIV_EXP;
            coarseExp_reg <= `DPL_RST_COARSE_EXP;
            coarseMult_reg <= `DPL_RST_COARSE_MULT;
            fineDiv_reg <= `DPL_RST_FINE_DIV;
            fineGain_reg <= `DPL_RST_FINE_GAIN;
            alphaMant_reg <= 12'h000;
            alphaUp_reg <= 5'h00;
            alphaDown_reg <= 3'h0;
            betaMant_reg <= 12'h000;
            betaShift_reg <= 3'h0;
            gammaMant_reg <= 12'h000;
            gammaShift_reg <= 3'h0;
            openFtw_reg <= 48'h0000_0000_0000;
        end else begin
            if (wrCtrl) begin
                closeLoop_reg <= regWdata[`DPL_CTRL_CLOSE_BIT];
                loopDivExp_reg <= regWdata[`DPL_CTRL_LDIV_LSB +: 5];
            end
            if (wrCoarse) begin
                coarseExp_reg <= regWdata[`DPL_COARSE_EXP_LSB +: 3];
                coarseMult_reg <= regWdata[`DPL_COARSE_MULT_LSB +: 6];
            end
            if (wrFine) begin
                fineDiv_reg <= regWdata[`DPL_FINE_DIV_LSB +: 4];
                fineGain_reg <= regWdata[`DPL_FINE_GAIN_LSB +: 8];
            end
            if (wrAlpha) begin
                alphaMant_reg <= regWdata[`DPL_MANT_LSB +: 12];
                // Up-shift above 22 is held at 22
                alphaUp_reg <= (regWdata[`DPL_SHIFT_LSB +: 5] > 5'h16) ? 5'h16 :
                    regWdata[`DPL_SHIFT_LSB +: 5];
                alphaDown_reg <= regWdata[`DPL_ALPHA_DOWN_LSB +: 3];
            end
            if (wrBeta) begin
                betaMant_reg <= regWdata[`DPL_MANT_LSB +: 12];
                betaShift_reg <= regWdata[`DPL_SHIFT_LSB +: 3];
            end
            if (wrGamma) begin
                gammaMant_reg <= regWdata[`DPL_MANT_LSB +: 12];
                gammaShift_reg <= regWdata[`DPL_SHIFT_LSB +: 3];
            end
            if (wrOpenLo) begin
                openFtw_reg[31:0] <= regWdata;
            end
            if (wrOpenHi) begin
                openFtw_reg[47:32] <= regWdata[15:0];
            end
        end
    end

    // Read mux; unmapped offsets read zero
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (regAddr)
            `DPL_OFS_CTRL: rdMux = {19'h0, loopDivExp_reg, 7'h00, closeLoop_reg};
            `DPL_OFS_COARSE: rdMux = {18'h0, coarseMult_reg, 5'h00, coarseExp_reg};
            `DPL_OFS_FINE: rdMux = {16'h0, fineGain_reg, 4'h0, fineDiv_reg};
            `DPL_OFS_ALPHA: rdMux = {5'h00, alphaDown_reg, 3'h0, alphaUp_reg,
                4'h0, alphaMant_reg};
            `DPL_OFS_BETA: rdMux = {13'h0, betaShift_reg, 4'h0, betaMant_reg};
            `DPL_OFS_GAMMA: rdMux = {13'h0, gammaShift_reg, 4'h0, gammaMant_reg};
            `DPL_OFS_FTW_LO: rdMux = ftw[31:0];
            `DPL_OFS_FTW_HI: rdMux = {16'h0000, ftw[47:32]};
            `DPL_OFS_OPEN_LO: rdMux = openFtw_reg[31:0];
            `DPL_OFS_OPEN_HI: rdMux = {16'h0000, openFtw_reg[47:32]};
            `DPL_OFS_PHASE_ERR: rdMux = phaseErr[31:0];
            `DPL_OFS_STATUS: rdMux = {30'h0, coarseState_reg};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata <= 32'h0000_0000;
        end else begin
            regRdata <= regRd ? rdMux : 32'h0000_0000;
        end
    end

    // Coarse detector: count clock periods between the two edges
    logic [CNT_W-1:0] cntInc;
    assign cntInc = (&coarseCnt_reg) ? coarseCnt_reg : coarseCnt_reg + 1'b1;
    always_comb begin
        coarseState_next = coarseState_reg;
        coarseCnt_next = coarseCnt_reg;
        coarseMeas_next = coarseMeas_reg;
        unique case (coarseState_reg)
            DPL_CD_IDLE: begin
                coarseCnt_next = {{(CNT_W-1){1'b0}}, 1'b1};
                if (refEdge && fbEdge) begin
                    coarseMeas_next = '0;
                end else if (refEdge) begin
                    coarseState_next = DPL_CD_REF_FIRST;
                end else if (fbEdge) begin
                    coarseState_next = DPL_CD_FB_FIRST;
                end
            end
            DPL_CD_REF_FIRST: begin
                coarseCnt_next = cntInc;
                if (fbEdge) begin
                    coarseMeas_next = $signed({1'b0, coarseCnt_reg});
                    coarseState_next = DPL_CD_IDLE;
                end
            end
            DPL_CD_FB_FIRST: begin
                coarseCnt_next = cntInc;
                if (refEdge) begin
                    coarseMeas_next = -$signed({1'b0, coarseCnt_reg});
                    coarseState_next = DPL_CD_IDLE;
                end
            end
            default: begin
                coarseState_next = DPL_CD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coarseState_reg <= DPL_CD_IDLE;
            coarseCnt_reg <= '0;
            coarseMeas_reg <= '0;
        end else begin
            coarseState_reg <= coarseState_next;
            coarseCnt_reg <= coarseCnt_next;
            coarseMeas_reg <= coarseMeas_next;
        end
    end

    // Fine detector time base: one tick per four times the divider
    logic [5:0] fineTerm;
    logic fineTick;
    assign fineTerm = {fineDiv_reg, 2'b00} - 6'h01;
    assign fineTick = (fineDiv_reg == 4'h0) || (fineCnt_reg >= fineTerm);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fineCnt_reg <= 6'h00;
            fineSample_reg <= '0;
        end else begin
            fineCnt_reg <= fineTick ? 6'h00 : fineCnt_reg + 6'h01;
            if (fineTick) begin
                fineSample_reg <= fineRaw;
            end
        end
    end

    // Gain scaling of both detectors and their sum
    logic signed [CNT_W+6:0] coarseProd;
    logic signed [PE_W-1:0] coarseScaled, fineScaled, errSum;
    logic signed [FINE_W+8:0] fineProd;
    logic [4:0] coarseShift;
    assign coarseProd = coarseMeas_reg * $signed({1'b0, coarseMult_reg});
    assign coarseShift = {2'b00, coarseExp_reg} + `DPL_COARSE_EXTRA_SHIFT;
    assign coarseScaled = PE_W'(coarseProd) <<< coarseShift;
    assign fineProd = fineSample_reg * $signed({1'b0, fineGain_reg});
    assign fineScaled = PE_W'(fineProd);
    assign errSum = coarseScaled + fineScaled;

    // Loop filter tick: clock divided by two to the programmed exponent
    logic [31:0] loopTerm;
    logic loopTick;
    assign loopTerm = (32'h0000_0001 << loopDivExp_reg) - 32'h0000_0001;
    assign loopTick = (loopCnt_reg >= loopTerm);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loopCnt_reg <= 32'h0000_0000;
            phaseErr <= '0;
            errValid <= 1'b0;
        end else begin
            loopCnt_reg <= loopTick ? 32'h0000_0000 : loopCnt_reg + 32'h0000_0001;
            errValid <= loopTick;
            if (loopTick) begin
                phaseErr <= errSum;
            end
        end
    end

    // Filter arithmetic: y = y + u, u = (1-g)u + a(x1 - (1+b-g)x2)
    logic [4:0] betaSh, gammaSh, alphaSh;
    logic signed [ACC_W+12:0] pBeta, pGammaX, pGammaU, pAlpha;
    logic signed [ACC_W+12:0] alphaUpd;
    logic signed [ACC_W-1:0] bX2, gX2, gU1, vIn, aTerm, uNext, xIn;
    assign betaSh = {2'b00, betaShift_reg} + `DPL_BG_BASE_SHIFT;
    assign gammaSh = {2'b00, gammaShift_reg} + `DPL_BG_BASE_SHIFT;
    assign alphaSh = {2'b00, alphaDown_reg} + `DPL_ALPHA_BASE_SHIFT;
    assign pBeta = x2_reg * $signed({1'b0, betaMant_reg});
    assign pGammaX = x2_reg * $signed({1'b0, gammaMant_reg});
    assign pGammaU = u1_reg * $signed({1'b0, gammaMant_reg});
    assign bX2 = ACC_W'(pBeta >>> betaSh);
    assign gX2 = ACC_W'(pGammaX >>> gammaSh);
    assign gU1 = ACC_W'(pGammaU >>> gammaSh);
    // Beta folded in as a subtracted magnitude, gamma as an added one
    assign vIn = x1_reg - x2_reg - bX2 + gX2;
    assign pAlpha = vIn * $signed({1'b0, alphaMant_reg});
    assign alphaUpd = (pAlpha <<< alphaUp_reg) >>> alphaSh;
    assign aTerm = ACC_W'(alphaUpd);
    assign uNext = u1_reg - gU1 + aTerm;
    assign xIn = ACC_W'(phaseErr);

    // Filter state advances once per delivered error sample
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            x1_reg <= '0;
            x2_reg <= '0;
            u1_reg <= '0;
            y_reg <= '0;
        end else if (errValid) begin
            x1_reg <= xIn;
            x2_reg <= x1_reg;
            u1_reg <= uNext;
            y_reg <= y_reg + uNext;
        end
    end

    // Tuning word select and phase accumulator
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ftw <= 48'h0000_0000_0000;
            ddsPhase <= 48'h0000_0000_0000;
        end else begin
            ftw <= closeLoop_reg ? y_reg[47:0] : openFtw_reg;
            ddsPhase <= ddsPhase + ftw;
        end
    end

endmodule // dpl_phase_loop

`default_nettype wire

//--- shared/dpl_pkg.sv
package dpl_pkg;
    // Coarse detector edge-ordering state
    typedef enum logic [1:0] {
        DPL_CD_IDLE = 2'b00,
        DPL_CD_REF_FIRST = 2'b01,
        DPL_CD_FB_FIRST = 2'b10
    } dpl_coarse_e;
endpackage

//--- shared/dpl_regs.svh
`ifndef DPL_REGS_SVH
`define DPL_REGS_SVH

// Register word offsets on the plain register port
`define DPL_ADDR_W 4
`define DPL_OFS_CTRL 4'h0
`define DPL_OFS_COARSE 4'h1
`define DPL_OFS_FINE 4'h2
`define DPL_OFS_ALPHA 4'h3
`define DPL_OFS_BETA 4'h4
`define DPL_OFS_GAMMA 4'h5
`define DPL_OFS_FTW_LO 4'h6
`define DPL_OFS_FTW_HI 4'h7
`define DPL_OFS_OPEN_LO 4'h8
`define DPL_OFS_OPEN_HI 4'h9
`define DPL_OFS_PHASE_ERR 4'hA
`define DPL_OFS_STATUS 4'hB

// Field positions
`define DPL_CTRL_CLOSE_BIT 0
`define DPL_CTRL_LDIV_LSB 8
`define DPL_COARSE_EXP_LSB 0
`define DPL_COARSE_MULT_LSB 8
`define DPL_FINE_DIV_LSB 0
`define DPL_FINE_GAIN_LSB 8
`define DPL_MANT_LSB 0
`define DPL_SHIFT_LSB 16
`define DPL_ALPHA_DOWN_LSB 24

// Reset values
`define DPL_RST_FINE_DIV 4'h5
`define DPL_RST_FINE_GAIN 8'hC8
`define DPL_RST_LDIV_EXP 5'h04
`define DPL_RST_COARSE_EXP 3'h0
`define DPL_RST_COARSE_MULT 6'h00

// Fixed scaling of the detectors and loop filter
`define DPL_COARSE_EXTRA_SHIFT 5'h06
`define DPL_BG_BASE_SHIFT 5'h0F
`define DPL_ALPHA_BASE_SHIFT 5'h0B
`define DPL_FINE_TB_SHIFT 2

`endif
